// File: verilog/pfr_telegram.sv
// Six-byte position response telegram framer with request decoding
// Functional notes
// - One function per request, diag highest priority
// - Response is exactly six bytes
// - Status bit 0 is internal error
// - Status bit 1 is tape error
// - Status bit 2 set while diagnostics stored
// - Status bit 3 set while marker held
// - Status bit 4 set while in standby
// - Status bits 6:5 carry reading quality
// - Status bit 7 always zero
// - Last byte is XOR of bytes 0-4
// - Position signed 32 bits, MSB first
// - Marker pending on two letters A-G, digit
// - Position still sent while marker pending
// - Marker request returns three ASCII characters
// - No stored marker answers E00
// - Diag request returns one stored entry
// - Diag codes E01 to E09 as ASCII
// - Standby request switches laser, motor off
// - Leaving standby takes a five second boot
// - Tape error reported while booting
`include "pfr_map.svh"
module pfr_telegram #(
   parameter int unsigned DIAG_DEPTH = 4,
   parameter int unsigned BOOT_CYCLES = `PFR_BOOT_TIME_MS * `PFR_CLK_KHZ
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Request bytes from the serial receiver
   input wire logic req_valid_i,
   input wire pfr_pkg::pfr_byte_t req_data_i,
   // Response bytes to the serial transmitter
   output pfr_pkg::pfr_byte_t tx_data_o,
   output logic tx_valid_o,
   input wire logic tx_ready_i,
   // Measurement front end
   input wire logic [31:0] position_i,
   input wire logic position_ok_i,
   input wire logic [1:0] quality_i,
   input wire logic internal_error_i,
   input wire logic marker_valid_i,
   input wire pfr_pkg::pfr_marker_t marker_i,
   input wire logic diag_valid_i,
   input wire logic [3:0] diag_code_i,
   // Scanner power
   output logic laser_en_o,
   output logic motor_en_o,
   output logic standby_o,
   // Register port
   input wire pfr_pkg::pfr_bus_t bus_i,
   output logic [31:0] bus_rdata_o
);
   import pfr_pkg::*;

   localparam int unsigned PW = $clog2(DIAG_DEPTH);
   localparam int unsigned BW = 32;

   generate
      if (DIAG_DEPTH < 2 || (DIAG_DEPTH & (DIAG_DEPTH - 1)) != 0) begin
         $error("DIAG_DEPTH must be a power of two of at least 2");
      end
      if (BOOT_CYCLES < 1) begin
         $error("BOOT_CYCLES must be at least 1");
      end
   endgenerate

   typedef struct packed {
      logic have_first;
      pfr_byte_t first;
      logic busy;
      logic [2:0] tx_idx;
      logic [5:0][7:0] frame;
      logic tx_valid;
      pfr_byte_t tx_data;
      logic standby;
      logic power_on;
      logic booting;
      logic [BW-1:0] boot_cnt;
      logic mk_held;
      pfr_marker_t mk;
      logic [DIAG_DEPTH-1:0][7:0] dq;
      logic [PW-1:0] dq_rd;
      logic [PW-1:0] dq_wr;
      logic [PW:0] dq_cnt;
      logic enable;
      logic [31:0] rdata;
   } pfr_state_t;

   pfr_state_t q;
   pfr_state_t d;

   function automatic logic is_letter(input pfr_byte_t c);
      is_letter = (c >= `PFR_ASCII_A) && (c <= `PFR_ASCII_G);
   endfunction

   function automatic logic is_digit(input pfr_byte_t c);
      is_digit = (c >= `PFR_ASCII_ZERO) && (c <= `PFR_ASCII_NINE);
   endfunction

   logic accept;
   logic mk_ok;
   logic push;
   logic pop;
   logic dq_full;
   logic tape_err;
   pfr_byte_t push_char;
   pfr_byte_t req;
   pfr_fn_t fn;
   pfr_status_t status;
   logic [31:0] data_word;
   pfr_byte_t xor_byte;

   always_comb begin
      d = q;
      accept = 1'b0;
      req = q.first;
      fn = PFR_FN_NONE;
      pop = 1'b0;
      data_word = 32'h0000_0000;

      // Booting counts down; the sensor has no valid position meanwhile
      if (q.booting) begin
         if (q.boot_cnt <= 1) begin
            d.booting = 1'b0;
         end else begin
            d.boot_cnt = q.boot_cnt - 1'b1;
         end
      end
      tape_err = !position_ok_i || q.standby || q.booting;

      status.unused7 = 1'b0;
      status.quality_hi = quality_i[1];
      status.quality_lo = quality_i[0];
      status.standby = q.standby;
      status.marker_pending = q.mk_held;
      status.diag_pending = (q.dq_cnt != '0);
      status.tape_error = tape_err;
      status.internal_error = internal_error_i;

      // Two-byte request; a failed check drops the pair
      if (req_valid_i && !q.busy && q.enable) begin
         if (!q.have_first) begin
            d.have_first = 1'b1;
            d.first = req_data_i;
         end else begin
            d.have_first = 1'b0;
            accept = (req_data_i == (q.first ^ `PFR_CHECK_KEY));
         end
      end

      // Priority decode, highest first
      if (req[`PFR_REQ_DIAG_BIT]) begin
         fn = PFR_FN_DIAG;
      end else if (req[`PFR_REQ_MARKER_BIT]) begin
         fn = PFR_FN_MARKER;
      end else if (req[`PFR_REQ_SLEEP_BIT]) begin
         fn = PFR_FN_SLEEP;
      end else if (req[`PFR_REQ_POS_BIT]) begin
         fn = PFR_FN_POS;
      end else if (req[`PFR_REQ_SINGLE_BIT]) begin
         fn = PFR_FN_SINGLE;
      end

      unique case (fn)
         PFR_FN_DIAG: begin
            data_word[23:16] = `PFR_ASCII_E;
            data_word[15:8] = `PFR_ASCII_ZERO;
            data_word[7:0] = `PFR_ASCII_ZERO;
            if (q.dq_cnt != '0) begin
               data_word[7:0] = q.dq[q.dq_rd];
               pop = accept;
            end
         end
         PFR_FN_MARKER: begin
            data_word[23:16] = `PFR_ASCII_E;
            data_word[15:8] = `PFR_ASCII_ZERO;
            data_word[7:0] = `PFR_ASCII_ZERO;
            if (q.mk_held) begin
               data_word[23:0] = {q.mk.c0, q.mk.c1, q.mk.c2};
            end
         end
         PFR_FN_SLEEP: begin
            data_word = 32'h0000_0000;
         end
         PFR_FN_POS, PFR_FN_SINGLE, PFR_FN_NONE: begin
            data_word = position_i;
         end
      endcase

      xor_byte = pfr_byte_t'(status) ^ data_word[31:24] ^
                 data_word[23:16] ^ data_word[15:8] ^ data_word[7:0];

      if (accept) begin
         d.frame[0] = pfr_byte_t'(status);
         d.frame[1] = data_word[31:24];
         d.frame[2] = data_word[23:16];
         d.frame[3] = data_word[15:8];
         d.frame[4] = data_word[7:0];
         d.frame[5] = xor_byte;
         d.busy = 1'b1;
         d.tx_idx = 3'h0;
         d.tx_valid = 1'b1;
         d.tx_data = pfr_byte_t'(status);
         if (fn == PFR_FN_MARKER) begin
            d.mk_held = 1'b0;
         end
         if (fn == PFR_FN_SLEEP) begin
            d.standby = 1'b1;
            d.booting = 1'b0;
         end else if (q.standby && !req[`PFR_REQ_SLEEP_BIT]) begin
            d.standby = 1'b0;
            d.booting = 1'b1;
            d.boot_cnt = BW'(BOOT_CYCLES);
         end
      end
      // Registered so the power pins come straight from a flop
      d.power_on = !d.standby;

      // Byte stream out, one byte per accepted handshake
      if (q.tx_valid && tx_ready_i) begin
         if (q.tx_idx == `PFR_LAST_IDX) begin
            d.tx_valid = 1'b0;
            d.busy = 1'b0;
         end else begin
            d.tx_idx = q.tx_idx + 3'h1;
            d.tx_data = q.frame[q.tx_idx + 3'h1];
         end
      end

      // A new marker wins over the clear of a served one
      mk_ok = marker_valid_i && is_letter(marker_i.c0) &&
              is_letter(marker_i.c1) && is_digit(marker_i.c2);
      if (mk_ok) begin
         d.mk_held = 1'b1;
         d.mk = marker_i;
      end

      // Diagnostic store; front end takes the single write slot first
      push = diag_valid_i;
      push_char = {`PFR_DIAG_PREFIX, diag_code_i};
      if (!diag_valid_i && bus_i.we && bus_i.addr == `PFR_OFS_DIAG) begin
         push = 1'b1;
         push_char = {`PFR_DIAG_PREFIX, bus_i.wdata[3:0]};
      end
      dq_full = (q.dq_cnt == (PW + 1)'(DIAG_DEPTH));
      if (push && !dq_full) begin
         d.dq[q.dq_wr] = push_char;
         d.dq_wr = q.dq_wr + 1'b1;
      end
      if (pop) begin
         d.dq_rd = q.dq_rd + 1'b1;
      end
      if (push && !dq_full && !pop) begin
         d.dq_cnt = q.dq_cnt + 1'b1;
      end else if (pop && !(push && !dq_full)) begin
         d.dq_cnt = q.dq_cnt - 1'b1;
      end

      // Register port
      if (bus_i.we && bus_i.addr == `PFR_OFS_CTRL) begin
         d.enable = bus_i.wdata[0];
      end
      d.rdata = 32'h0000_0000;
      if (bus_i.re) begin
         unique case (bus_i.addr)
            `PFR_OFS_CTRL: d.rdata = {31'h0, q.enable};
            `PFR_OFS_STATUS: d.rdata = {24'h0, pfr_byte_t'(status)};
            `PFR_OFS_DIAG: d.rdata = 32'(q.dq_cnt);
            `PFR_OFS_POS: d.rdata = position_i;
            default: d.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= '0;
         q.enable <= `PFR_CTRL_RESET;
         q.power_on <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from state
   assign tx_data_o = q.tx_data;
   assign tx_valid_o = q.tx_valid;
   assign laser_en_o = q.power_on;
   assign motor_en_o = q.power_on;
   assign standby_o = q.standby;
   assign bus_rdata_o = q.rdata;

endmodule

// File: pkg/pfr_map.svh
// Constants of the position response telegram framer
`ifndef PFR_MAP_SVH
`define PFR_MAP_SVH
`define PFR_REQ_DIAG_BIT 0
`define PFR_REQ_MARKER_BIT 1
`define PFR_REQ_SLEEP_BIT 2
`define PFR_REQ_POS_BIT 3
`define PFR_REQ_SINGLE_BIT 4
`define PFR_CHECK_KEY 8'h00
`define PFR_FRAME_LEN 6
`define PFR_LAST_IDX 3'h5
`define PFR_OFS_CTRL 4'h0
`define PFR_OFS_STATUS 4'h4
`define PFR_OFS_DIAG 4'h8
`define PFR_OFS_POS 4'hC
`define PFR_CTRL_RESET 1'b1
`define PFR_ASCII_E 8'h45
`define PFR_ASCII_ZERO 8'h30
`define PFR_ASCII_NINE 8'h39
`define PFR_ASCII_A 8'h41
`define PFR_ASCII_G 8'h47
`define PFR_DIAG_PREFIX 4'h3
`define PFR_BOOT_TIME_MS 5000
`define PFR_CLK_KHZ 10000
`endif

// File: pkg/pfr_pkg.sv
// Types of the position response telegram framer
package pfr_pkg;
   typedef logic [7:0] pfr_byte_t;
   typedef struct packed {
      logic unused7;
      logic quality_hi;
      logic quality_lo;
      logic standby;
      logic marker_pending;
      logic diag_pending;
      logic tape_error;
      logic internal_error;
   } pfr_status_t;
   typedef struct packed {
      pfr_byte_t c0;
      pfr_byte_t c1;
      pfr_byte_t c2;
   } pfr_marker_t;
   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic we;
      logic re;
   } pfr_bus_t;
   typedef enum logic [2:0] {
      PFR_FN_DIAG = 3'b000,
      PFR_FN_MARKER = 3'b001,
      PFR_FN_SLEEP = 3'b010,
      PFR_FN_POS = 3'b011,
      PFR_FN_SINGLE = 3'b100,
      PFR_FN_NONE = 3'b101
   } pfr_fn_t;
endpackage

// File: bench/pfr_telegram_props.sv
// Checker of the response telegram framer, bound to its top module
module pfr_telegram_props (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Response link and front end
   input wire pfr_pkg::pfr_byte_t tx_data_o,
   input wire logic tx_valid_o,
   input wire logic tx_ready_i,
   input wire logic position_ok_i,
   input wire logic [1:0] quality_i,
   input wire logic internal_error_i,
   // Power and registers
   input wire logic laser_en_o,
   input wire logic motor_en_o,
   input wire logic standby_o,
   input wire pfr_pkg::pfr_bus_t bus_i,
   input wire logic [31:0] bus_rdata_o
);
   timeunit 1ns;
   timeprecision 1ns;
   import pfr_pkg::*;
   logic [2:0] idx_q, idx_d;
   pfr_byte_t acc_q, acc_d;
   logic hs;
   assign hs = tx_valid_o && tx_ready_i;
   always_comb begin
      idx_d = idx_q;
      acc_d = acc_q;
      if (hs) begin
         idx_d = (idx_q == 3'h5) ? 3'h0 : idx_q + 3'h1;
         acc_d = (idx_q == 3'h0) ? tx_data_o : acc_q ^ tx_data_o;
      end
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         idx_q <= 3'h0;
         acc_q <= 8'h00;
      end else begin
         idx_q <= idx_d;
         acc_q <= acc_d;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   stat_bit7_a: assert property (tx_valid_o && idx_q == 3'h0
      |-> !tx_data_o[7]) else $error("status bit 7 set");
   frame_end_a: assert property (hs && idx_q == 3'h5
      |=> !tx_valid_o) else $error("frame longer than six bytes");
   xor_byte_a: assert property (tx_valid_o && idx_q == 3'h5
      |-> tx_data_o == acc_q) else $error("check byte wrong");
   byte_hold_a: assert property (tx_valid_o && !tx_ready_i
      |=> tx_valid_o && $stable(tx_data_o)) else $error("byte dropped");
   // Status is frozen at acceptance, so compare against the inputs then
   quality_a: assert property ($rose(tx_valid_o)
      |-> tx_data_o[6:5] == $past(quality_i)) else $error("quality wrong");
   int_err_a: assert property ($rose(tx_valid_o)
      |-> tx_data_o[0] == $past(internal_error_i))
      else $error("error flag wrong");
   tape_err_a: assert property ($rose(tx_valid_o)
      && !$past(position_ok_i) |-> tx_data_o[1])
      else $error("tape flag clear");
   laser_off_a: assert property (laser_en_o == !standby_o
      && motor_en_o == !standby_o) else $error("power state wrong");
   rdata_idle_a: assert property (!$past(bus_i.re)
      |-> bus_rdata_o == 32'h0) else $error("read data outside slot");
endmodule

bind pfr_telegram pfr_telegram_props i_pfr_telegram_props (.clk_i,
   .rst_n_i, .tx_data_o, .tx_valid_o, .tx_ready_i, .position_ok_i,
   .quality_i, .internal_error_i, .laser_en_o, .motor_en_o, .standby_o,
   .bus_i, .bus_rdata_o);

// File: bench/pfr_host.sv
// Host controller model: sends request pairs and collects responses
module pfr_host (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Request bytes
   output logic req_valid_o,
   output pfr_pkg::pfr_byte_t req_data_o,
   // Response bytes
   input wire pfr_pkg::pfr_byte_t tx_data_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o
);
   timeunit 1ns;
   timeprecision 1ns;
   import pfr_pkg::*;
   initial begin
      req_valid_o = 1'b0;
      req_data_o = 8'h5A;
      tx_ready_o = 1'b0;
   end
   // Slow mode takes a byte only every other cycle
   task automatic poll(input pfr_byte_t cmd, input logic bad,
                       input logic slow, output logic [47:0] f,
                       output int n);
      int t;
      f = '0;
      n = 0;
      t = 0;
      req_valid_o <= 1'b1;
      req_data_o <= cmd;
      @(posedge clk_i);
      req_data_o <= bad ? ~cmd : cmd;
      @(posedge clk_i);
      req_valid_o <= 1'b0;
      req_data_o <= ~cmd;
      while (n < 6 && t < 40) begin
         tx_ready_o <= !slow || t[0];
         @(posedge clk_i);
         t++;
         if (tx_valid_i && tx_ready_o) begin
            f = {f[39:0], tx_data_i};
            n++;
         end
      end
      tx_ready_o <= 1'b0;
   endtask
endmodule

// File: bench/pfr_telegram_tb.sv
// Self-checking testbench of the response telegram framer
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
   $display("ERROR %0t got %h exp %h", $time, g, e); end end
module pfr_telegram_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import pfr_pkg::*;
   localparam int BOOT = 30;
   localparam logic [31:0] POS = 32'h8123_4567;
   logic clk_i, rst_n_i, req_valid_i, tx_valid_o, tx_ready_i;
   pfr_byte_t req_data_i, tx_data_o;
   logic [31:0] position_i, bus_rdata_o;
   logic position_ok_i, internal_error_i, marker_valid_i, diag_valid_i;
   logic [1:0] quality_i;
   pfr_marker_t marker_i;
   logic [3:0] diag_code_i;
   logic laser_en_o, motor_en_o, standby_o;
   pfr_bus_t bus_i;
   int fails = 0, check_count = 0, cyc = 0;
   pfr_telegram #(.DIAG_DEPTH(4), .BOOT_CYCLES(BOOT)) i_pfr_telegram (
      .clk_i, .rst_n_i, .req_valid_i, .req_data_i, .tx_data_o, .tx_valid_o,
      .tx_ready_i, .position_i, .position_ok_i, .quality_i,
      .internal_error_i, .marker_valid_i, .marker_i, .diag_valid_i,
      .diag_code_i, .laser_en_o, .motor_en_o, .standby_o, .bus_i,
      .bus_rdata_o);
   pfr_host i_pfr_host (.clk_i, .rst_n_i, .req_valid_o(req_valid_i),
      .req_data_o(req_data_i), .tx_data_i(tx_data_o),
      .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i));
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   function automatic logic [47:0] fr(input pfr_byte_t s,
                                      input logic [31:0] d);
      return {s, d, s ^ d[31:24] ^ d[23:16] ^ d[15:8] ^ d[7:0]};
   endfunction
   task automatic poll(input pfr_byte_t c, input logic [47:0] e,
                       input logic slow = 1'b0);
      logic [47:0] f;
      int n;
      i_pfr_host.poll(c, 1'b0, slow, f, n);
      `CHK(f, e)
   endtask
   task automatic nores(input pfr_byte_t c, input logic bad);
      logic [47:0] f;
      int n;
      i_pfr_host.poll(c, bad, 1'b0, f, n);
      `CHK(n, 0)
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus_i <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_i);
      bus_i <= '0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      bus_i <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clk_i);
      bus_i <= '0;
      // Mid-cycle, while the read data stand
      @(negedge clk_i);
      `CHK(bus_rdata_o, e)
      @(posedge clk_i);
   endtask
   task automatic front(input logic mv, input pfr_marker_t m,
                        input logic dv, input logic [3:0] c);
      marker_valid_i <= mv;
      marker_i <= m;
      diag_valid_i <= dv;
      diag_code_i <= c;
      @(posedge clk_i);
      marker_valid_i <= 1'b0;
      diag_valid_i <= 1'b0;
   endtask
   task automatic t_regs();
      rd(4'h0, 32'h1);
      rd(4'h4, 32'h40);
      wr(4'h2, 32'hFFFF_FFFF);
      rd(4'h2, 32'h0);
      wr(4'h8, 32'h3);
      rd(4'h8, 32'h1);
      rd(4'h4, 32'h44);
      poll(8'h01, fr(8'h44, 32'h0045_3033));
      rd(4'h8, 32'h0);
      wr(4'h0, 32'h0);
      nores(8'h08, 1'b0);
      wr(4'h0, 32'h1);
      $display("t_regs done");
   endtask
   task automatic t_pos();
      poll(8'h08, fr(8'h40, POS), 1'b1);
      $display("t_pos done");
   endtask
   task automatic t_marker();
      front(1'b1, {8'h41, 8'h42, 8'h33}, 1'b1, 4'h5);
      poll(8'h1F, fr(8'h4C, 32'h0045_3035));
      poll(8'h08, fr(8'h48, POS));
      poll(8'h0E, fr(8'h48, 32'h0041_4233));
      `CHK(standby_o, 1'b0)
      poll(8'h02, fr(8'h40, 32'h0045_3030));
      front(1'b1, {8'h41, 8'h48, 8'h33}, 1'b0, 4'h0);
      poll(8'h10, fr(8'h40, POS));
      nores(8'h08, 1'b1);
      $display("t_marker done");
   endtask
   task automatic t_standby();
      poll(8'h04, fr(8'h40, 32'h0));
      `CHK(laser_en_o, 1'b0)
      `CHK(motor_en_o, 1'b0)
      poll(8'h08, fr(8'h52, POS));
      poll(8'h08, fr(8'h42, POS));
      repeat (BOOT + 10) @(posedge clk_i);
      poll(8'h08, fr(8'h40, POS));
      `CHK(laser_en_o, 1'b1)
      internal_error_i <= 1'b1;
      position_ok_i <= 1'b0;
      poll(8'h08, fr(8'h43, POS));
      $display("t_standby done");
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Whole run is a few hundred cycles; the ceiling leaves wide margin
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         end_of_test();
      end
   end
   initial begin
      rst_n_i = 1'b0;
      bus_i = '0;
      position_i = POS;
      position_ok_i = 1'b1;
      quality_i = 2'b10;
      internal_error_i = 1'b0;
      marker_valid_i = 1'b0;
      marker_i = '0;
      diag_valid_i = 1'b0;
      diag_code_i = 4'h0;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      t_regs();
      t_pos();
      t_marker();
      t_standby();
      end_of_test();
   end
endmodule
